// ---- iosd_io_space_regs.v ----
// i/o space decode with general storage and legacy port registers
// What this block does
// [RL1] every location is reachable by data-space loads and stores.
// [RL2] bit set and clear work on i/o addresses 0x00 to 0x1f.
// [RL3] skip-on-bit tests read one selected bit in 0x00 to 0x1f.
// [RL4] short i/o read and write reach only i/o addresses 0x00 to 0x3f.
// [RL5] a low i/o register sits at its i/o address plus 0x20 in data space.
// [RL6] the region 0x60 to 0x1ff is reachable only by loads and stores.
// [RL7] bit clear zeroes the bit named by bitSel whatever wrData holds; no flag clears on a written one.
// [RL8] bit set and clear change only the named bit.
// [RL9] software leaves reserved bits and addresses alone.
// [RL10] three 8-bit general storage registers hold and return any value.
// [RL11] legacy port a and c output and direction registers act as storage.
// [RL12] the port a input address is reserved, not storage.
// [RL13] the port c input address is reserved, not storage.
// [RL14] all storage registers reset to zero.
`timescale 1ns/1ns
`include "iosd_consts.vh"
module iosd_io_space_regs (
	// clock and reset
	input  wire       clk_sys,
	input  wire       reset_n,
	// cpu access
	input  wire       opValid,
	input  wire [2:0] opCode,
	input  wire [8:0] opAddr,
	input  wire [2:0] bitSel,
	input  wire [7:0] wrData,
	// answer
	output reg  [7:0] rdData,
	output reg        bitTest,
	output reg        accessError,
	// extended region hand-off
	output wire       extSelect,
	output wire [8:0] extAddr
);
	localparam NREG = 7;
	reg  [7:0] store_reg [0:NREG-1];
	reg  [7:0] store_next;
	reg  [2:0] slot;
	reg        slotHit;
	wire [8:0] ioAddr;
	wire       legal;
	wire       isWrite;
	wire       isBit;
	wire [7:0] oldValue;
	wire [7:0] newValue;
	wire       bitValue;
	wire       reservedHit;
	integer    i;

	function [3:0] decode_slot;
		input [8:0] a;
		begin
			case (a)
				`IOSD_GS0:       decode_slot = 4'h8; // RL10
				`IOSD_GS1:       decode_slot = 4'h9; // RL10
				`IOSD_GS2:       decode_slot = 4'ha; // RL10
				`IOSD_PA_OUTPUT: decode_slot = 4'hb; // RL11
				`IOSD_PA_DIR:    decode_slot = 4'hc; // RL11
				`IOSD_PC_OUTPUT: decode_slot = 4'hd; // RL11
				`IOSD_PC_DIR:    decode_slot = 4'he; // RL11
				default:         decode_slot = 4'h0;
			endcase
		end
	endfunction

	iosd_addr_map u_map (
		.opCode  (opCode),
		.opAddr  (opAddr),
		.ioAddr  (ioAddr),
		.legal   (legal),
		.isWrite (isWrite),
		.isBit   (isBit)
	);

	always @* begin
		slot    = 3'h0;
		slotHit = 1'b0;
		case (decode_slot(ioAddr))
			4'h8: begin slot = 3'h0; slotHit = 1'b1; end
			4'h9: begin slot = 3'h1; slotHit = 1'b1; end
			4'ha: begin slot = 3'h2; slotHit = 1'b1; end
			4'hb: begin slot = 3'h3; slotHit = 1'b1; end
			4'hc: begin slot = 3'h4; slotHit = 1'b1; end
			4'hd: begin slot = 3'h5; slotHit = 1'b1; end
			4'he: begin slot = 3'h6; slotHit = 1'b1; end // RL11
			default: begin slot = 3'h0; slotHit = 1'b0; end
		endcase
	end

	// port a input and port c input are never storage
	assign reservedHit = (ioAddr == `IOSD_PA_INPUT) || (ioAddr == `IOSD_PC_INPUT); // RL12 RL13
	assign oldValue    = slotHit ? store_reg[slot] : 8'h00;
	assign extSelect   = opValid && legal && (ioAddr >= `IOSD_EXT_LO - `IOSD_DATA_IO_OFFSET); // RL6
	assign extAddr     = opAddr;

	iosd_bit_op u_bit (
		.opCode   (opCode),
		.bitSel   (bitSel),
		.oldValue (oldValue),
		.wrData   (wrData),
		.newValue (newValue),
		.bitValue (bitValue)
	);

	always @* begin
		store_next = newValue; // RL8
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < NREG; i = i + 1) begin
				store_reg[i] <= `IOSD_RESET_VALUE; // RL14
			end
		end else if (opValid && legal && isWrite && slotHit && !reservedHit) begin
			store_reg[slot] <= store_next; // RL10 RL11
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rdData      <= 8'h00;
			bitTest     <= 1'b0;
			accessError <= 1'b0;
		end else begin
			accessError <= opValid && !legal; // RL4 RL2
			if (opValid && legal && !isWrite) begin
				rdData  <= (slotHit && !reservedHit) ? oldValue : 8'h00; // RL12 RL13
				bitTest <= isBit ? bitValue : 1'b0; // RL3
			end
		end
	end
endmodule

// ---- iosd_consts.vh ----
// constants for the i/o space decode and storage register block
`ifndef IOSD_CONSTS_VH
`define IOSD_CONSTS_VH
`define IOSD_DATA_IO_OFFSET   9'h020
`define IOSD_IO_TOP           9'h03f
`define IOSD_BIT_TOP          9'h01f
`define IOSD_EXT_LO           9'h060
`define IOSD_EXT_HI           9'h1ff
`define IOSD_PA_INPUT         9'h000
`define IOSD_PA_DIR           9'h001
`define IOSD_PA_OUTPUT        9'h002
`define IOSD_PC_INPUT         9'h006
`define IOSD_PC_DIR           9'h007
`define IOSD_PC_OUTPUT        9'h008
`define IOSD_GS0              9'h01e
`define IOSD_GS1              9'h02a
`define IOSD_GS2              9'h02b
`define IOSD_RESET_VALUE      8'h00
`define IOSD_OP_NONE          3'h0
`define IOSD_OP_IO_READ       3'h1
`define IOSD_OP_IO_WRITE      3'h2
`define IOSD_OP_BIT_SET       3'h3
`define IOSD_OP_BIT_CLEAR     3'h4
`define IOSD_OP_BIT_TEST      3'h5
`define IOSD_OP_DS_LOAD       3'h6
`define IOSD_OP_DS_STORE      3'h7
`endif

// ---- iosd_addr_map.v ----
// maps each cpu access onto an i/o address and checks its legality
`timescale 1ns/1ns
`include "iosd_consts.vh"
module iosd_addr_map (
	// request
	input  wire [2:0] opCode,
	input  wire [8:0] opAddr,
	// result
	output reg  [8:0] ioAddr,
	output reg        legal,
	output reg        isWrite,
	output reg        isBit
);
	always @* begin
		ioAddr  = opAddr;
		legal   = 1'b0;
		isWrite = 1'b0;
		isBit   = 1'b0;
		case (opCode)
			`IOSD_OP_IO_READ: begin
				legal = (opAddr <= `IOSD_IO_TOP); // RL4
			end
			`IOSD_OP_IO_WRITE: begin
				legal   = (opAddr <= `IOSD_IO_TOP); // RL4
				isWrite = 1'b1;
			end
			`IOSD_OP_BIT_SET, `IOSD_OP_BIT_CLEAR: begin
				legal   = (opAddr <= `IOSD_BIT_TOP); // RL2
				isWrite = 1'b1;
				isBit   = 1'b1;
			end
			`IOSD_OP_BIT_TEST: begin
				legal = (opAddr <= `IOSD_BIT_TOP); // RL3
				isBit = 1'b1;
			end
			`IOSD_OP_DS_LOAD, `IOSD_OP_DS_STORE: begin
				// low range sits 0x20 higher in data space
				ioAddr  = opAddr - `IOSD_DATA_IO_OFFSET; // RL5
				legal   = (opAddr >= `IOSD_DATA_IO_OFFSET); // RL1 RL6
				isWrite = (opCode == `IOSD_OP_DS_STORE);
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end
endmodule

// ---- iosd_bit_op.v ----
// merges a whole-byte or single-bit write into the old byte
`timescale 1ns/1ns
`include "iosd_consts.vh"
module iosd_bit_op (
	// operands
	input  wire [2:0] opCode,
	input  wire [2:0] bitSel,
	input  wire [7:0] oldValue,
	input  wire [7:0] wrData,
	// result
	output reg  [7:0] newValue,
	output wire       bitValue
);
	wire [7:0] bitMask;
	assign bitMask  = 8'h01 << bitSel;
	assign bitValue = oldValue[bitSel]; // RL3
	always @* begin
		case (opCode)
			`IOSD_OP_BIT_SET:   newValue = oldValue | bitMask; // RL8
			`IOSD_OP_BIT_CLEAR: newValue = oldValue & ~bitMask; // RL7 RL8
			default:            newValue = wrData;
		endcase
	end
endmodule

// ---- iosd_io_space_regs_properties.sv ----
// checker for the i/o space decode block
`timescale 1ns/1ns
module iosd_io_space_regs_properties (
	// clock and reset
	input wire       clk_sys,
	input wire       reset_n,
	// access and answer
	input wire       opValid,
	input wire [2:0] opCode,
	input wire [8:0] opAddr,
	input wire [7:0] rdData,
	input wire       accessError,
	input wire       extSelect,
	input wire [8:0] extAddr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire ioOp  = opValid && opCode inside {3'h1, 3'h2};
	wire bitOp = opValid && opCode inside {3'h3, 3'h4, 3'h5};
	wire dsOp  = opValid && opCode[2:1] == 2'b11;
	chk_io_range: assert property (ioOp && opAddr > 9'h03f |=> accessError)
		else $error("io range");
	chk_bit_range: assert property (bitOp && opAddr > 9'h01f |=> accessError)
		else $error("bit range");
	chk_ds_low: assert property (dsOp && opAddr < 9'h020 |=> accessError)
		else $error("ds low");
	chk_ds_legal: assert property (dsOp && opAddr >= 9'h020 |=> !accessError)
		else $error("ds legal");
	chk_ext_select: assert property (dsOp && opAddr >= 9'h060 |-> extSelect && extAddr == opAddr)
		else $error("ext select");
	chk_ext_only_ds: assert property (extSelect |-> dsOp)
		else $error("ext only");
	chk_rd_hold: assert property (!opValid |=> $stable(rdData))
		else $error("rd hold");
	chk_reset_zero: assert property ($rose(reset_n) |-> rdData == 8'h00 && !accessError)
		else $error("reset value");
endmodule
bind iosd_io_space_regs iosd_io_space_regs_properties u_props (.clk_sys(clk_sys),
	.reset_n(reset_n), .opValid(opValid), .opCode(opCode), .opAddr(opAddr), .rdData(rdData),
	.accessError(accessError), .extSelect(extSelect), .extAddr(extAddr));

// ---- iosd_cpu_model.sv ----
// cpu core model issuing one access per call
`timescale 1ns/1ns
module iosd_cpu_model (
	// clock
	input  wire        clk_sys,
	// access
	output logic       opValid = 1'b0,
	output logic [2:0] opCode = 3'h0,
	output logic [8:0] opAddr = 9'h000,
	output logic [2:0] bitSel = 3'h0,
	output logic [7:0] wrData = 8'h00,
	// answer
	input  wire  [7:0] rdData,
	input  wire        bitTest,
	input  wire        accessError
);
	task automatic access(input [2:0] c, input [8:0] a, input [2:0] b, input [7:0] d,
		output [7:0] rd, output bt, output er);
		@(posedge clk_sys);
		opValid <= 1'b1;
		opCode <= c;
		opAddr <= a;
		bitSel <= b;
		wrData <= d;
		@(posedge clk_sys);
		opValid <= 1'b0;
		opAddr <= ~a;
		wrData <= ~d;
		#1;
		rd = rdData;
		bt = bitTest;
		er = accessError;
	endtask
endmodule

// ---- io_space_decode_gp_regs_tb_top.sv ----
// testbench for the i/o space decode block
`timescale 1ns/1ns
`include "iosd_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module io_space_decode_gp_regs_tb_top;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	wire         opValid, bitTest, accessError;
	wire  [2:0]  opCode, bitSel;
	wire  [8:0]  opAddr;
	wire  [7:0]  wrData, rdData;
	logic [7:0]  rd;
	logic        bt, er;
	int          fails = 0;
	int          checks = 0;
	logic [8:0]  regs [7] = '{9'h001, 9'h002, 9'h007, 9'h008, 9'h01e, 9'h02a, 9'h02b};
	logic [11:0] bad [7] = '{12'h240, 12'h440, 12'h620, 12'h820, 12'ha20, 12'hc1f, 12'he1f};
	iosd_io_space_regs u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .opValid(opValid),
		.opCode(opCode), .opAddr(opAddr), .bitSel(bitSel), .wrData(wrData), .rdData(rdData),
		.bitTest(bitTest), .accessError(accessError), .extSelect(), .extAddr());
	iosd_cpu_model u_cpu (.clk_sys(clk_sys), .opValid(opValid), .opCode(opCode),
		.opAddr(opAddr), .bitSel(bitSel), .wrData(wrData), .rdData(rdData),
		.bitTest(bitTest), .accessError(accessError));
	task automatic go(input [2:0] c, input [8:0] a, input [2:0] b, input [7:0] d);
		u_cpu.access(c, a, b, d, rd, bt, er);
	endtask
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		foreach (regs[i]) begin
			go(`IOSD_OP_DS_LOAD, regs[i] + 9'h020, 3'h0, 8'h00);
			`CHK(rd, 8'h00)
			go(`IOSD_OP_IO_WRITE, regs[i], 3'h0, 8'h5a ^ 8'(i));
		end
		foreach (regs[i]) begin
			go(`IOSD_OP_DS_LOAD, regs[i] + 9'h020, 3'h0, 8'h00);
			`CHK(rd, 8'h5a ^ 8'(i))
			go(`IOSD_OP_IO_READ, regs[i], 3'h0, 8'h00);
			`CHK(rd, 8'h5a ^ 8'(i))
		end
		go(`IOSD_OP_DS_STORE, 9'h03e, 3'h0, 8'ha5);
		go(`IOSD_OP_BIT_SET, 9'h01e, 3'h1, 8'hff);
		go(`IOSD_OP_BIT_CLEAR, 9'h01e, 3'h0, 8'h00);
		go(`IOSD_OP_BIT_TEST, 9'h01e, 3'h7, 8'h00);
		`CHK(bt, 1'b1)
		go(`IOSD_OP_IO_READ, 9'h01e, 3'h0, 8'h00);
		`CHK(rd, 8'ha6)
		for (int j = 0; j < 7; j += 6) begin
			go(`IOSD_OP_IO_READ, 9'(j), 3'h0, 8'h00);
			`CHK(rd, 8'h00)
			go(`IOSD_OP_DS_LOAD, 9'(j) + 9'h020, 3'h0, 8'h00);
			`CHK(rd, 8'h00)
		end
		foreach (bad[k]) begin
			go(bad[k][11:9], bad[k][8:0], 3'h0, 8'h00);
			`CHK(er, 1'b1)
		end
		go(`IOSD_OP_DS_LOAD, 9'h060, 3'h0, 8'h00);
		`CHK(er, 1'b0)
		end_of_test();
	end
endmodule
